// >>> pkg/fcl_consts.svh
`ifndef FCL_CONSTS_SVH
`define FCL_CONSTS_SVH
// timing at the 20 MHz system clock
`define FCL_CLK_NS 50
`define FCL_ROM_ACCESS_NS 100
`define FCL_ROM_WAIT ((`FCL_ROM_ACCESS_NS + `FCL_CLK_NS - 1) / `FCL_CLK_NS)
`define FCL_SYNC_LAT 2
`define FCL_CLEAR_CYCLES 8
`define FCL_FIFO_DEPTH 16
// boot image layout
`define FCL_ROM_LAST 8'hff
`define FCL_CTRL_WORD 7'h7f
// register offsets and fields
`define FCL_REG_STATUS 4'h0
`define FCL_REG_CTRL 4'h1
`define FCL_REG_ROMADR 4'h2
`define FCL_REG_CMD 4'h3
`define FCL_CMD_RELOAD 0
`define FCL_CMD_CLEAR 1
`define FCL_CTRL_DIV_HI 14
`define FCL_CTRL_DIV_LO 13
`define FCL_CTRL_RESET 16'h0000
`endif

// >>> pkg/fcl_pkg.sv
package fcl_pkg;
    // boot loader states, gray from idle through to done; the strb to addr loop flips two bits
    typedef enum logic [2:0] {
        fcl_st_idle = 3'b000,
        fcl_st_addr = 3'b001,
        fcl_st_capt = 3'b011,
        fcl_st_strb = 3'b010,
        fcl_st_done = 3'b110
    } fcl_state_e;
    // one load toward coefficient memory or control register
    typedef struct packed {
        logic is_ctrl;
        logic [6:0] addr;
        logic [15:0] data;
    } fcl_wr_s;
    // pin inputs as one synchronised group
    typedef struct packed {
        logic boot_source_strap;
        logic byte_load_strap;
        logic load_wen_n;
        logic chip_sel_n;
        logic reg_sel;
        logic filter_enable;
        logic clear_n;
        logic result_output_enable_n;
        logic [7:0] coefficient_address;
        logic [15:0] coefficient_bus;
    } fcl_pins_s;
endpackage : fcl_pkg

// >>> hw/fcl_load_ctrl.sv
`timescale 1ns/1ps
`include "fcl_consts.svh"

module fcl_fifo #(
    parameter int WIDTH = 24,
    parameter int DEPTH = `FCL_FIFO_DEPTH
) (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic in_valid,
    input wire logic [WIDTH-1:0] in_data,
    output logic in_ready,
    output logic out_valid,
    output logic [WIDTH-1:0] out_data,
    input wire logic out_ready
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic [AW:0] count;
    logic push;
    logic pop;

    // handshakes from the fill level
    assign in_ready = (count < (AW+1)'(DEPTH));
    assign out_valid = (count != '0);
    assign out_data = mem[rd_ptr];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    // storage, depth is a power of two so pointers wrap
    always_ff @(posedge clk_sys) begin
        if (push) begin
            mem[wr_ptr] <= in_data;
        end
    end

    // pointers and level
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count <= '0;
        end else begin
            if (push) wr_ptr <= wr_ptr + 1'b1;
            if (pop) rd_ptr <= rd_ptr + 1'b1;
            if (push && !pop) count <= count + 1'b1;
            else if (pop && !push) count <= count - 1'b1;
        end
    end
endmodule : fcl_fifo

module fcl_load_ctrl (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic boot_source_strap,
    input wire logic byte_load_strap,
    input wire logic load_wen_n_in,
    output logic load_wen_n_out,
    output logic load_wen_n_oe,
    input wire logic chip_sel_n,
    input wire logic reg_sel,
    input wire logic [7:0] coefficient_address_in,
    output logic [7:0] coefficient_address_out,
    output logic coefficient_address_oe,
    input wire logic [15:0] coefficient_bus,
    input wire logic filter_enable,
    input wire logic clear_n,
    input wire logic result_output_enable_n,
    input wire logic [31:0] result_data,
    output logic [31:0] result_bus_out,
    output logic result_bus_oe,
    output logic sample_clock_out,
    output logic busy,
    output logic acc_clear,
    output logic filter_run,
    output logic [15:0] ctrl_reg,
    output logic coef_wr_valid,
    output logic [6:0] coef_wr_addr,
    output logic [15:0] coef_wr_data,
    input wire logic coef_wr_ready,
    input wire logic [3:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [15:0] reg_rdata
);
    fcl_pkg::fcl_pins_s pin_raw;
    fcl_pkg::fcl_pins_s pin_s1;
    fcl_pkg::fcl_pins_s pin_s;
    fcl_pkg::fcl_state_e state;
    fcl_pkg::fcl_wr_s push_word;
    fcl_pkg::fcl_wr_s pop_word;
    logic [7:0] rom_addr;
    logic [1:0] wait_cnt;
    logic [7:0] lo_byte;
    logic [3:0] clr_cnt;
    logic [2:0] div_cnt;
    logic boot_pend;
    logic host_en_q;
    logic host_mode;
    logic host_take;
    logic host_push;
    logic boot_push;
    logic fifo_ready;
    logic fifo_valid;
    logic fifo_pop_ready;
    logic cmd_wr;

    // divider limit for the selected filter mode
    function automatic logic [2:0] fcl_div_max(input logic [1:0] sel);
        fcl_div_max = 3'((4'h1 << sel) - 4'h1);
    endfunction : fcl_div_max

    // all pins pass two flops before use
    assign pin_raw = '{boot_source_strap, byte_load_strap, load_wen_n_in, chip_sel_n,
        reg_sel, filter_enable, clear_n, result_output_enable_n, coefficient_address_in,
        coefficient_bus};
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            pin_s1 <= '1;
            pin_s <= '1;
        end else begin
            pin_s1 <= pin_raw;
            pin_s <= pin_s1;
        end
    end

    assign host_mode = pin_s.boot_source_strap;
    assign cmd_wr = reg_wr && (reg_addr == `FCL_REG_CMD);

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            clr_cnt <= 4'(`FCL_CLEAR_CYCLES);
        end else if (!pin_s.clear_n || (cmd_wr && reg_wdata[`FCL_CMD_CLEAR])) begin
            clr_cnt <= 4'(`FCL_CLEAR_CYCLES);
        end else if (clr_cnt != 4'h0) begin
            clr_cnt <= clr_cnt - 4'h1;
        end
    end
    assign acc_clear = (clr_cnt != 4'h0);

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            boot_pend <= 1'b1;
        end else if (cmd_wr && reg_wdata[`FCL_CMD_RELOAD] && !host_mode) begin
            boot_pend <= 1'b1;
        end else if (!acc_clear && (state == fcl_pkg::fcl_st_idle)) begin
            boot_pend <= 1'b0;
        end
    end

    // host strobe edge, gated by chip select
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) host_en_q <= 1'b0;
        else host_en_q <= host_mode && !pin_s.load_wen_n && !pin_s.chip_sel_n;
    end
    assign host_take = host_mode && !pin_s.load_wen_n && !pin_s.chip_sel_n && !host_en_q
        && (state == fcl_pkg::fcl_st_idle);
    // bytes pair on address bit zero
    assign host_push = host_take && (pin_s.byte_load_strap || pin_s.coefficient_address[0]);
    assign boot_push = (state == fcl_pkg::fcl_st_capt) && rom_addr[0];

    // select bit steers host target, word drops top bit
    always_comb begin
        push_word = '0;
        if (boot_push) begin
            push_word.is_ctrl = (rom_addr[7:1] == `FCL_CTRL_WORD);
            push_word.addr = rom_addr[7:1];
            push_word.data = {pin_s.coefficient_bus[7:0], lo_byte};
        end else if (pin_s.byte_load_strap) begin
            push_word.is_ctrl = pin_s.reg_sel;
            push_word.addr = pin_s.coefficient_address[6:0];
            push_word.data = pin_s.coefficient_bus;
        end else begin
            push_word.is_ctrl = pin_s.reg_sel;
            push_word.addr = pin_s.coefficient_address[7:1];
            push_word.data = {pin_s.coefficient_bus[7:0], lo_byte};
        end
    end

    // low byte holding for byte pairs
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            lo_byte <= 8'h00;
        end else if ((state == fcl_pkg::fcl_st_capt) && !rom_addr[0]) begin
            lo_byte <= pin_s.coefficient_bus[7:0];
        end else if (host_take && !pin_s.byte_load_strap && !pin_s.coefficient_address[0]) begin
            lo_byte <= pin_s.coefficient_bus[7:0];
        end
    end

    // load queue, control words drain at once
    fcl_fifo #(.WIDTH($bits(fcl_pkg::fcl_wr_s)), .DEPTH(`FCL_FIFO_DEPTH)) u_fifo (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .in_valid(boot_push || host_push),
        .in_data(push_word),
        .in_ready(fifo_ready),
        .out_valid(fifo_valid),
        .out_data(pop_word),
        .out_ready(fifo_pop_ready)
    );
    assign fifo_pop_ready = pop_word.is_ctrl || coef_wr_ready;
    assign coef_wr_valid = fifo_valid && !pop_word.is_ctrl;
    assign coef_wr_addr = pop_word.addr;
    assign coef_wr_data = pop_word.data;

    // control register from drained control words
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) ctrl_reg <= `FCL_CTRL_RESET;
        else if (fifo_valid && pop_word.is_ctrl) ctrl_reg <= pop_word.data;
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            state <= fcl_pkg::fcl_st_idle;
            rom_addr <= 8'h00;
            wait_cnt <= 2'h0;
        end else begin
            case (state)
                fcl_pkg::fcl_st_idle: begin
                    if (boot_pend && !acc_clear && !host_mode) begin
                        state <= fcl_pkg::fcl_st_addr;
                        rom_addr <= 8'h00;
                        wait_cnt <= 2'(`FCL_ROM_WAIT + `FCL_SYNC_LAT - 1);
                    end
                end
                fcl_pkg::fcl_st_addr: begin
                    if (wait_cnt == 2'h0) state <= fcl_pkg::fcl_st_capt;
                    else wait_cnt <= wait_cnt - 2'h1;
                end
                fcl_pkg::fcl_st_capt: begin
                    if (!rom_addr[0] || fifo_ready) state <= fcl_pkg::fcl_st_strb;
                end
                fcl_pkg::fcl_st_strb: begin
                    if (rom_addr == `FCL_ROM_LAST) begin
                        state <= fcl_pkg::fcl_st_done;
                    end else begin
                        state <= fcl_pkg::fcl_st_addr;
                        rom_addr <= rom_addr + 8'h01;
                        wait_cnt <= 2'(`FCL_ROM_WAIT + `FCL_SYNC_LAT - 1);
                    end
                end
                default: state <= fcl_pkg::fcl_st_idle;
            endcase
        end
    end

    // slave strobe and ROM address pins
    assign load_wen_n_out = (state != fcl_pkg::fcl_st_strb);
    assign load_wen_n_oe = !host_mode;
    assign coefficient_address_out = rom_addr;
    assign coefficient_address_oe = !host_mode;

    // busy while anything is in progress
    assign busy = acc_clear || boot_pend || (state != fcl_pkg::fcl_st_idle) || fifo_valid;

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            div_cnt <= 3'h0;
            sample_clock_out <= 1'b0;
        end else begin
            sample_clock_out <= (div_cnt == 3'h0);
            if (div_cnt >= fcl_div_max(ctrl_reg[`FCL_CTRL_DIV_HI:`FCL_CTRL_DIV_LO])) begin
                div_cnt <= 3'h0;
            end else begin
                div_cnt <= div_cnt + 3'h1;
            end
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            result_bus_oe <= 1'b0;
            result_bus_out <= 32'h0000_0000;
        end else begin
            result_bus_oe <= !pin_s.result_output_enable_n;
            result_bus_out <= result_data;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) filter_run <= 1'b0;
        else filter_run <= pin_s.filter_enable && !busy;
    end

    // register read port, data one cycle after strobe
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata <= 16'h0000;
        end else if (reg_rd) begin
            if (reg_addr == `FCL_REG_STATUS) begin
                reg_rdata <= {9'h000, !fifo_ready, acc_clear, busy, host_mode, state};
            end else if (reg_addr == `FCL_REG_CTRL) begin
                reg_rdata <= ctrl_reg;
            end else if (reg_addr == `FCL_REG_ROMADR) begin
                reg_rdata <= {8'h00, rom_addr};
            end else begin
                reg_rdata <= 16'h0000;
            end
        end else begin
            reg_rdata <= 16'h0000;
        end
    end

    // boot step sequences
    sequence fcl_capt_go;
        (state == fcl_pkg::fcl_st_capt) && (!rom_addr[0] || fifo_ready);
    endsequence
    sequence fcl_strobe;
        (state == fcl_pkg::fcl_st_strb) && !load_wen_n_out;
    endsequence

    boot_strobe_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        fcl_capt_go |=> fcl_strobe)
        else $error("slave strobe missing after capture");
    host_cs_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        host_push |-> !pin_s.chip_sel_n && !pin_s.load_wen_n && !host_en_q)
        else $error("host write without select");
    boot_pair_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (state == fcl_pkg::fcl_st_capt) && !rom_addr[0] |-> !boot_push)
        else $error("boot pushed half word");
    rom_drive_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        fcl_strobe and (rom_addr != `FCL_ROM_LAST) |=> coefficient_address_oe
        && coefficient_address_out == $past(rom_addr) + 8'h01) else $error("ROM address skipped");
    div_pulse_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        sample_clock_out && ctrl_reg[14:13] == 2'b11 && $stable(ctrl_reg)
        |=> !sample_clock_out [*7])
        else $error("divide by eight pulse spacing");
    oen_reg_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        $rose(pin_s.result_output_enable_n) |=> !result_bus_oe)
        else $error("result bus still driven");
    boot_busy_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (state != fcl_pkg::fcl_st_idle) || acc_clear |-> busy)
        else $error("busy low during operation");
    clear_hold_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        !pin_s.clear_n |=> acc_clear [*8])
        else $error("clear not held");
    boot_end_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
        fcl_strobe and (rom_addr == `FCL_ROM_LAST) |=> ##1 (state == fcl_pkg::fcl_st_idle))
        else $error("boot did not finish");
endmodule : fcl_load_ctrl

// >>> sim/fcl_rom_model.sv
`timescale 1ns/1ps
// byte-wide boot rom on the coefficient bus, upper lines carry the inverse byte
module fcl_rom_model #(
    parameter int ACCESS_NS = 100
) (
    input wire logic [7:0] rom_addr,
    input wire logic rom_sel,
    output logic [15:0] rom_data
);
    initial begin
        rom_data = 16'h0000;
    end
    // byte per address
    // old data turns over until the access time has run out
    always @(rom_addr or rom_sel) begin
        rom_data = ~rom_data;
        if (rom_sel) begin
            rom_data <= #(ACCESS_NS) {~(rom_addr ^ 8'h5a), rom_addr ^ 8'h5a};
        end
    end
endmodule : fcl_rom_model

// >>> sim/tb_fcl_load_ctrl.sv
`timescale 1ns/1ps
module tb_fcl_load_ctrl;
    typedef struct {
        logic [15:0] ctrl;
        int pulses;
    } fcl_row_s;
    logic clk_sys = 1'b0, rst_n = 1'b0, boot_source_strap = 1'b0, byte_load_strap = 1'b1;
    logic host_wen_n = 1'b1, chip_sel_n = 1'b1, reg_sel = 1'b0, filter_enable = 1'b0;
    logic clear_n = 1'b1, result_output_enable_n = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
    logic coef_wr_ready = 1'b0, sink_en = 1'b0;
    logic [7:0] host_addr = 8'h00, coefficient_address_out;
    logic [15:0] host_data = 16'h0000, reg_wdata = 16'h0000, rd;
    logic [15:0] ctrl_reg, coef_wr_data, reg_rdata, rom_data;
    logic [31:0] result_data = 32'h0, result_bus_out;
    logic [3:0] reg_addr = 4'h0;
    logic [6:0] coef_wr_addr;
    logic load_wen_n_out, load_wen_n_oe, coefficient_address_oe, result_bus_oe;
    logic sample_clock_out, busy, acc_clear, filter_run, coef_wr_valid;
    logic [22:0] got_q[$];
    int miscompares = 0, check_count = 0, cycles = 0, strobes = 0, n;
    fcl_row_s rows[4] = '{'{16'h6000, 4}, '{16'h0000, 32}, '{16'h4000, 8}, '{16'h2000, 16}};
    // two-way pins resolved from the enables
    wire logic [7:0] addr_pin = coefficient_address_oe ? coefficient_address_out : host_addr;
    wire logic wen_pin = load_wen_n_oe ? load_wen_n_out : host_wen_n;
    wire logic [15:0] cbus = coefficient_address_oe ? rom_data : host_data;

    always #25 clk_sys = ~clk_sys;

    fcl_load_ctrl dut (
        .clk_sys, .rst_n, .boot_source_strap, .byte_load_strap, .load_wen_n_in(wen_pin),
        .load_wen_n_out, .load_wen_n_oe, .chip_sel_n, .reg_sel, .coefficient_address_in(addr_pin),
        .coefficient_address_out, .coefficient_address_oe, .coefficient_bus(cbus), .filter_enable,
        .clear_n, .result_output_enable_n, .result_data, .result_bus_out, .result_bus_oe,
        .sample_clock_out, .busy, .acc_clear, .filter_run, .ctrl_reg, .coef_wr_valid,
        .coef_wr_addr, .coef_wr_data, .coef_wr_ready, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
        .reg_rdata
    );

    fcl_rom_model rom (
        .rom_addr(coefficient_address_out),
        .rom_sel(coefficient_address_oe),
        .rom_data(rom_data)
    );

    // stalling sink, write capture, slave strobe count and timeout
    always @(posedge clk_sys) begin
        cycles <= cycles + 1;
        coef_wr_ready <= sink_en & ~coef_wr_ready;
        if (coef_wr_valid && coef_wr_ready) begin
            got_q.push_back({coef_wr_addr, coef_wr_data});
        end
        if (load_wen_n_oe && !load_wen_n_out) begin
            strobes <= strobes + 1;
        end
        if (cycles == 20000) begin
            miscompares++;
            end_sim();
        end
    end

    task automatic end_sim();
        $display("checks %0d miscompares %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : end_sim

    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            miscompares++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk

    task automatic tick(input int k);
        repeat (k) @(posedge clk_sys);
        #1;
    endtask : tick

    task automatic reg_write(input logic [3:0] a, input logic [15:0] d);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
        #1;
    endtask : reg_write

    task automatic reg_read(input logic [3:0] a, output logic [15:0] d);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        #1;
        d = reg_rdata;
    endtask : reg_read

    // host load: strobe low four cycles, then released six
    task automatic host_load(input logic sel, input logic cs_n, input logic [7:0] a,
                             input logic [15:0] d);
        @(posedge clk_sys);
        reg_sel <= sel;
        chip_sel_n <= cs_n;
        host_addr <= a;
        host_data <= d;
        host_wen_n <= 1'b0;
        repeat (4) @(posedge clk_sys);
        host_wen_n <= 1'b1;
        tick(6);
    endtask : host_load

    task automatic wait_busy_low(input int bound);
        n = 0;
        while (busy !== 1'b0 && n < bound) begin
            tick(1);
            n++;
        end
        chk("busy low", busy, 1'b0);
    endtask : wait_busy_low

    task automatic pulses(input int k);
        n = 0;
        repeat (k) begin
            tick(1);
            n += (sample_clock_out === 1'b1);
        end
    endtask : pulses

    task automatic clear_len();
        n = 0;
        while (acc_clear !== 1'b1 && n < 10) begin
            tick(1);
            n++;
        end
        chk("busy in clear", busy, 1'b1);
        n = 0;
        while (acc_clear === 1'b1 && n < 40) begin
            tick(1);
            n++;
        end
        chk("run held", filter_run, 1'b0);
    endtask : clear_len

    initial begin
        // boot comes first after reset; the table rows run after a second reset in host mode
        tick(16);
        chk("busy in reset", busy, 1'b1);
        chk("clear in reset", acc_clear, 1'b1);
        chk("strobe idle", load_wen_n_out, 1'b1);
        rst_n <= 1'b1;
        tick(12);
        chk("rom addr out", coefficient_address_oe, 1'b1);
        chk("strobe out", load_wen_n_oe, 1'b1);
        chk("busy in boot", busy, 1'b1);
        // sink stalled until the buffer is full
        n = 0;
        rd = 16'h0;
        while (rd[6] !== 1'b1 && n < 300) begin
            reg_read(4'h0, rd);
            n++;
        end
        chk("buffer full", rd[6], 1'b1);
        sink_en <= 1'b1;
        wait_busy_low(4000);
        chk("slave strobes", strobes, 256);
        chk("boot words", got_q.size(), 127);
        for (int w = 0; w < 127; w++) begin
            chk("boot word", got_q[w], {w[6:0], (8'(2 * w + 1) ^ 8'h5a), (8'(2 * w) ^ 8'h5a)});
        end
        chk("boot ctrl", ctrl_reg, 16'ha5a4);
        pulses(32);
        chk("boot divider", n, 16);
        // reload command repeats the whole boot sequence
        reg_write(4'h3, 16'h0001);
        chk("reload busy", busy, 1'b1);
        wait_busy_low(2500);
        chk("reload strobes", strobes, 512);
        reg_read(4'h2, rd);
        chk("rom addr reg", rd, 16'h00ff);
        // second reset in host mode
        boot_source_strap <= 1'b1;
        rst_n <= 1'b0;
        tick(16);
        rst_n <= 1'b1;
        tick(4);
        chk("strobe input", load_wen_n_oe, 1'b0);
        chk("addr input", coefficient_address_oe, 1'b0);
        wait_busy_low(40);
        got_q.delete();
        foreach (rows[i]) begin
            host_load(1'b1, 1'b0, 8'h00, rows[i].ctrl);
            chk("ctrl load", ctrl_reg, rows[i].ctrl);
            reg_read(4'h1, rd);
            chk("ctrl read", rd, rows[i].ctrl);
            pulses(32);
            chk("divider", n, rows[i].pulses);
        end
        chk("no coef on ctrl", got_q.size(), 0);
        // word load with top bit set, deselected load, then a byte pair
        host_load(1'b0, 1'b0, 8'h85, 16'h1234);
        host_load(1'b0, 1'b1, 8'h10, 16'hbeef);
        byte_load_strap <= 1'b0;
        host_load(1'b0, 1'b0, 8'h06, 16'h0034);
        host_load(1'b0, 1'b0, 8'h07, 16'h0012);
        wait_busy_low(40);
        chk("host writes", got_q.size(), 2);
        chk("word load", got_q[0], {7'h05, 16'h1234});
        chk("byte pair", got_q[1], {7'h03, 16'h1234});
        chk("host strobes", strobes, 512);
        // clears by pin and by command
        // enable after configuration
        filter_enable <= 1'b1;
        clear_n <= 1'b0;
        tick(1);
        clear_n <= 1'b1;
        clear_len();
        chk("pin clear", n, 8);
        reg_write(4'h3, 16'h0002);
        clear_len();
        chk("cmd clear", n, 8);
        wait_busy_low(20);
        tick(3);
        chk("filter run", filter_run, 1'b1);
        reg_read(4'hf, rd);
        chk("unmapped read", rd, 16'h0000);
        // result bus enable lags by the two pin flops and its register
        result_data <= 32'hcafe0123;
        result_output_enable_n <= 1'b0;
        tick(2);
        chk("still floating", result_bus_oe, 1'b0);
        tick(2);
        chk("bus driven", result_bus_oe, 1'b1);
        chk("bus value", result_bus_out, 32'hcafe0123);
        result_output_enable_n <= 1'b1;
        tick(4);
        chk("bus floated", result_bus_oe, 1'b0);
        end_sim();
    end
endmodule : tb_fcl_load_ctrl
